/* logic/bsctap_regs.vh */
// Constants of the boundary scan test access port
`ifndef BSCTAP_REGS_VH
`define BSCTAP_REGS_VH
`define BSCTAP_IR_W 4
`define BSCTAP_IR_CAPTURE 4'h1
`define BSCTAP_I_BYPASS 4'h0
`define BSCTAP_I_SAMPLE 4'h1
`define BSCTAP_I_IDCODE 4'h2
`define BSCTAP_I_USER 4'h3
`define BSCTAP_I_CLAMP 4'h4
`define BSCTAP_I_HIGHZ 4'h5
`define BSCTAP_I_EXTEST 4'h7
`define BSCTAP_I_IFCTL 4'h8
`define BSCTAP_I_RDREG 4'h9
`define BSCTAP_I_WRREG 4'hA
`define BSCTAP_LEN_BYP 6'h01
`define BSCTAP_LEN_BS 6'h18
`define BSCTAP_LEN_ID 6'h20
`define BSCTAP_LEN_IF 6'h01
`define BSCTAP_LEN_REG 6'h0F
`define BSCTAP_ADDR_W 7
`define BSCTAP_DATA_W 8
`define BSCTAP_PADS 12
`define BSCTAP_BS_W 24
`define BSCTAP_ADDR_RST 7'h00
`define BSCTAP_IF_RST 1'b0
`endif

/* logic/bsctap.v */
// Boundary scan test access port with register access commands
//
// Contract
// - Decode bypass, sample/preload, idcode, user, clamp, highz, extest, interface on/off.
// - Code 9 reads register by 7-bit address; code 10 writes 8 data bits.
// - All test logic advances only on test clock edges, nothing else.
// - Static test clock leaves state and all register contents unchanged.
// - Pull-ups enabled on test clock, mode select and data input pins.
// - Mode select sampled on rising test clock edge picks next state.
// - Five cycles of mode select high reach Test-Logic-Reset from anywhere.
// - Test-Logic-Reset loads the identification instruction.
// - Data input sampled on rising edge into instruction or selected chain.
// - Data output updated on falling edge from the accessed chain.
// - Data output undriven whenever not shifting.
// - Bypass passes data through one stage without disturbing the device.
// - Chain length follows instruction; test cells can override pins.
// - Each pad has a control cell and a data cell that both captures the input and drives the output.
// - Interface command with 1 at Update-DR disables host link, enables access.
// - Read access: capture current address, shift new, update takes it.
`timescale 1ns/1ns
`default_nettype none
`include "bsctap_regs.vh"
module bsctap #(
  parameter [31:0] ID_VALUE = 32'h1000_0001,  // Arbitrary value
  parameter [31:0] USER_VALUE = 32'h0000_0000 // Arbitrary value
) (
  input wire clk,                          // System clock 100 MHz
  input wire rst_n,                        // Async reset, active low
  input wire tck,                          // Test clock pin
  input wire tms,                          // Mode select pin
  input wire tdi,                          // Test data in pin
  output reg tdo,                          // Test data out
  output reg tdo_oe,                       // Test data out drive enable
  output reg pullup_en,                    // Pull-ups on test inputs
  input wire [`BSCTAP_PADS-1:0] pad_in,    // Pad input levels
  input wire [`BSCTAP_PADS-1:0] func_out,  // Functional pad data
  input wire [`BSCTAP_PADS-1:0] func_oe,   // Functional pad enables
  output reg [`BSCTAP_PADS-1:0] pad_out,   // Pad data to pads
  output reg [`BSCTAP_PADS-1:0] pad_oe,    // Pad enables to pads
  output reg host_if_off,                  // Host and SAM link disabled
  output reg [`BSCTAP_ADDR_W-1:0] reg_addr,  // Internal register address
  output reg [`BSCTAP_DATA_W-1:0] reg_wdata, // Internal write data
  output reg reg_wr,                       // Internal write pulse
  input wire [`BSCTAP_DATA_W-1:0] reg_rdata  // Internal read data
);
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDS = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIS = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  reg rst_s1_q, rst_s2_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_i_n = rst_s2_q;

  reg [2:0] pin_s1_q, pin_s2_q;
  reg tck_d_q;
  reg [`BSCTAP_PADS-1:0] pad_s1_q, pad_s2_q;
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      tck_d_q <= 1'b1;
      pad_s1_q <= 12'h000;
      pad_s2_q <= 12'h000;
    end else begin
      pin_s1_q <= {tck, tms, tdi};
      pin_s2_q <= pin_s1_q;
      tck_d_q <= pin_s2_q[2];
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end
  // Edges of the test clock; a stopped clock yields none
  wire tck_rise = pin_s2_q[2] & ~tck_d_q;
  wire tck_fall = ~pin_s2_q[2] & tck_d_q;
  wire tms_s = pin_s2_q[1];
  wire tdi_s = pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine
  reg [15:0] st_q, st_d;
  always @* begin
    case (st_q)
      S_TLR: st_d = tms_s ? S_TLR : S_RTI;
      S_RTI: st_d = tms_s ? S_SDS : S_RTI;
      S_SDS: st_d = tms_s ? S_SIS : S_CDR;
      S_CDR: st_d = tms_s ? S_E1D : S_SHD;
      S_SHD: st_d = tms_s ? S_E1D : S_SHD;
      S_E1D: st_d = tms_s ? S_UDR : S_PDR;
      S_PDR: st_d = tms_s ? S_E2D : S_PDR;
      S_E2D: st_d = tms_s ? S_UDR : S_SHD;
      S_UDR: st_d = tms_s ? S_SDS : S_RTI;
      S_SIS: st_d = tms_s ? S_TLR : S_CIR;
      S_CIR: st_d = tms_s ? S_E1I : S_SHI;
      S_SHI: st_d = tms_s ? S_E1I : S_SHI;
      S_E1I: st_d = tms_s ? S_UIR : S_PIR;
      S_PIR: st_d = tms_s ? S_E2I : S_PIR;
      S_E2I: st_d = tms_s ? S_UIR : S_SHI;
      S_UIR: st_d = tms_s ? S_SDS : S_RTI;
      default: st_d = S_TLR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode and chain length
  reg [`BSCTAP_IR_W-1:0] ir_q, irsh_q;
  reg [31:0] dr_q;
  reg [`BSCTAP_BS_W-1:0] bs_upd_q;
  reg [5:0] len;
  reg [3:0] ir_eff;
  always @* begin
    ir_eff = ir_q;
    case (ir_q)
      `BSCTAP_I_SAMPLE, `BSCTAP_I_IDCODE, `BSCTAP_I_USER, `BSCTAP_I_CLAMP,
      `BSCTAP_I_HIGHZ, `BSCTAP_I_EXTEST, `BSCTAP_I_IFCTL: ir_eff = ir_q;
      `BSCTAP_I_RDREG, `BSCTAP_I_WRREG: begin
        ir_eff = host_if_off ? ir_q : `BSCTAP_I_BYPASS;
      end
      default: ir_eff = `BSCTAP_I_BYPASS;
    endcase
    case (ir_eff)
      `BSCTAP_I_SAMPLE, `BSCTAP_I_EXTEST: len = `BSCTAP_LEN_BS;
      `BSCTAP_I_IDCODE, `BSCTAP_I_USER: len = `BSCTAP_LEN_ID;
      `BSCTAP_I_IFCTL: len = `BSCTAP_LEN_IF;
      `BSCTAP_I_RDREG, `BSCTAP_I_WRREG: len = `BSCTAP_LEN_REG;
      default: len = `BSCTAP_LEN_BYP;
    endcase
  end

  // Capture values: control cells see the enable, data cells the pad
  reg [`BSCTAP_BS_W-1:0] bs_cap;
  integer k;
  always @* begin
    bs_cap = {`BSCTAP_BS_W{1'b0}};
    for (k = 0; k < `BSCTAP_PADS; k = k + 1) begin
      bs_cap[2*k] = pad_s2_q[k];
      bs_cap[2*k+1] = pad_oe[k];
    end
  end

  // Shift with the data input entering at the chain's top
  reg [31:0] dr_sh;
  integer i;
  integer j;
  always @* begin
    dr_sh = 32'h0000_0000;
    for (i = 0; i < 32; i = i + 1) begin
      if (i == len - 1)
        dr_sh[i] = tdi_s;
      else if (i < 31)
        dr_sh[i] = dr_q[i+1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test-clock driven state, stepped on rising edges only
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      st_q <= S_TLR;
      ir_q <= `BSCTAP_I_IDCODE;
      irsh_q <= 4'h0;
      dr_q <= 32'h0000_0000;
      bs_upd_q <= 24'h000000;
      host_if_off <= `BSCTAP_IF_RST;
      reg_addr <= `BSCTAP_ADDR_RST;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      if (tck_rise) begin
        st_q <= st_d;
        case (st_q)
          S_TLR: ir_q <= `BSCTAP_I_IDCODE;
          S_SIS: if (tms_s) ir_q <= `BSCTAP_I_IDCODE;
          S_CIR: irsh_q <= `BSCTAP_IR_CAPTURE;
          S_SHI: irsh_q <= {tdi_s, irsh_q[3:1]};
          S_UIR: ir_q <= irsh_q;
          S_CDR: begin
            case (ir_eff)
              `BSCTAP_I_SAMPLE, `BSCTAP_I_EXTEST: dr_q <= {8'h00, bs_cap};
              `BSCTAP_I_IDCODE: dr_q <= ID_VALUE;
              `BSCTAP_I_USER: dr_q <= USER_VALUE;
              `BSCTAP_I_IFCTL: dr_q <= {31'h0, host_if_off};
              `BSCTAP_I_RDREG: dr_q <= {17'h0, reg_rdata, reg_addr};
              `BSCTAP_I_WRREG: dr_q <= {17'h0, reg_wdata, reg_addr};
              default: dr_q <= 32'h0000_0000;
            endcase
          end
          S_SHD: dr_q <= dr_sh;
          S_UDR: begin
            case (ir_eff)
              `BSCTAP_I_SAMPLE, `BSCTAP_I_EXTEST: bs_upd_q <= dr_q[23:0];
              `BSCTAP_I_IFCTL: host_if_off <= dr_q[0];
              `BSCTAP_I_RDREG: reg_addr <= dr_q[6:0];
              `BSCTAP_I_WRREG: begin
                reg_addr <= dr_q[6:0];
                reg_wdata <= dr_q[14:7];
                reg_wr <= 1'b1;
              end
              default: bs_upd_q <= bs_upd_q;
            endcase
          end
          default: irsh_q <= irsh_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data output on falling edges, pad override
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      pullup_en <= 1'b1;
      pad_out <= 12'h000;
      pad_oe <= 12'h000;
    end else begin
      pullup_en <= 1'b1;
      if (tck_fall) begin
        tdo <= (st_q == S_SHI) ? irsh_q[0] : dr_q[0];
        tdo_oe <= (st_q == S_SHI) || (st_q == S_SHD);
      end
      for (j = 0; j < `BSCTAP_PADS; j = j + 1) begin
        case (ir_eff)
          `BSCTAP_I_EXTEST, `BSCTAP_I_CLAMP: begin
            pad_out[j] <= bs_upd_q[2*j];
            pad_oe[j] <= bs_upd_q[2*j+1];
          end
          `BSCTAP_I_HIGHZ: begin
            pad_out[j] <= 1'b0;
            pad_oe[j] <= 1'b0;
          end
          default: begin
            pad_out[j] <= func_out[j];
            pad_oe[j] <= func_oe[j];
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* verif/bsctap_assertions.sv */
// Concurrent checks on the test access port outputs
`timescale 1ns/1ns
`default_nettype none
module bsctap_assertions (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic tck, // Test clock
  input wire logic tdo, // Data out
  input wire logic tdo_oe, // Out enable
  input wire logic pullup_en, // Pull-ups
  input wire logic host_if_off, // Link off
  input wire logic [6:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr // Write pulse
);
  logic tck_q;
  logic [3:0] cnt_q;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // Cycles since the test clock last moved
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_q <= 1'h0;
      cnt_q <= 4'h0;
    end else begin
      tck_q <= tck;
      cnt_q <= (tck != tck_q) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    end
  end
  ////////////////////////////////////////////////////////////////
  pullup_on_a: assert property (pullup_en)
    else $error("pull-up enable low");
  tdo_hold_a: assert property (tck |-> $stable(tdo) && $stable(tdo_oe))
    else $error("tdo moved with test clock high");
  static_hold_a: assert property (cnt_q >= 4'h8 |-> !reg_wr && $stable(tdo)
    && $stable(host_if_off) && $stable(reg_addr) && $stable(reg_wdata))
    else $error("state moved with test clock still");
  tdo_rise_a: assert property ($rose(tdo_oe) |-> !tck && cnt_q < 4'h5)
    else $error("tdo enabled off the falling edge");
  iface_edge_a: assert property ($changed(host_if_off) |-> cnt_q < 4'h7)
    else $error("link switch not tied to test clock");
  wr_pulse_a: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse too long");
  wr_gate_a: assert property (reg_wr |-> host_if_off)
    else $error("write while link on");
  wdata_gate_a: assert property ($changed(reg_wdata) |-> ##[0:8] reg_wr)
    else $error("write data moved without pulse");
endmodule
bind bsctap bsctap_assertions u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .tck(tck),
  .tdo(tdo),
  .tdo_oe(tdo_oe),
  .pullup_en(pullup_en),
  .host_if_off(host_if_off),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr)
);
`default_nettype wire

/* verif/bsctap_tester.sv */
// Behavioural scan tester on the far side of the port
`timescale 1ns/1ns
`default_nettype none
module bsctap_tester (
  output var logic tck, // Test clock
  output var logic tms, // Mode select
  output var logic tdi, // Data in
  input wire logic tdo, // Data out
  input wire logic tdo_oe // Out enable
);
  logic so;
  logic so_oe;
  int oe_miss = 0;
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // Drive after the fall, sample at the rise, clock rests low
  task automatic step(input logic m, input logic d);
    // Keeps every link edge off the system clock edges
    if ($time % 5 != 2) #((7 - $time % 5) % 5);
    tms = m;
    tdi = d;
    #62 tck = 1'h1;
    // Undriven line reads as the inverse of the last bit
    so = tdo_oe ? tdo : ~tdo;
    so_oe = tdo_oe;
    #63 tck = 1'h0;
  endtask
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = so;
      if (so_oe !== 1'h1) oe_miss++;
    end
  endtask
  task automatic reset_tap();
    repeat (5) step(1'h1, 1'h1);
    step(1'h0, 1'h1);
  endtask
  task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
    step(1'h0, 1'h1);
    shift(n, din, dout);
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
  endtask
  task automatic scan(input logic [3:0] ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic [3:0] irc);
    logic [31:0] t;
    step(1'h1, 1'h1);
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
    step(1'h0, 1'h1);
    shift(4, {28'h0, ir}, t);
    irc = t[3:0];
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
    dr(n, din, dout);
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the boundary scan port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [31:0] ID = 32'h5A3C96E1; // Arbitrary value
  localparam logic [31:0] USR = 32'h2468ACE1; // Arbitrary value
  localparam logic [11:0] DV = 12'h5A3;
  localparam logic [11:0] PIN = 12'h3C6;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_rdata = 8'h00;
  wire tck, tms, tdi, tdo, tdo_oe, pullup_en, host_if_off, reg_wr;
  wire [11:0] pad_out, pad_oe;
  wire [6:0] reg_addr;
  wire [7:0] reg_wdata;
  int errors = 0;
  int check_count = 0;
  int wr_seen = 0;
  logic [31:0] d;
  logic [3:0] irc;
  always #5 clk = ~clk;
  always @(negedge clk) reg_rdata <= {reg_addr, 1'h1};
  always @(negedge clk) if (reg_wr === 1'h1) wr_seen++;
  bsctap #(.ID_VALUE(ID), .USER_VALUE(USR)) dut (.clk(clk), .rst_n(rst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pullup_en(pullup_en), .pad_in(PIN),
    .func_out(12'h0F0), .func_oe(12'h00F), .pad_out(pad_out), .pad_oe(pad_oe),
    .host_if_off(host_if_off), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata));
  bsctap_tester jt (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sc(input logic [3:0] ir, input int n, input logic [31:0] din);
    jt.scan(ir, n, din, d, irc);
    repeat (5) @(negedge clk);
    chk("ir capture", 32'h1, irc);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_ids();
    logic [3:0] codes [5] = '{4'h0, 4'h4, 4'h5, 4'h9, 4'hF};
    chk("pullup", 32'h1, pullup_en);
    chk("host_if_off", 32'h0, host_if_off);
    jt.reset_tap();
    jt.dr(32, 32'h0, d);
    chk("default id", ID, d);
    foreach (codes[i]) begin
      sc(codes[i], 4, 32'hB);
      chk("bypass out", 32'h6, d);
    end
    sc(4'h2, 32, 32'h0);
    chk("id", ID, d);
    sc(4'h3, 32, 32'h0);
    chk("user", USR, d);
    $display("done: ids");
  endtask
  task automatic t_pads();
    logic [23:0] p;
    logic [23:0] e;
    for (int k = 0; k < 12; k++) begin
      p[2*k] = DV[k];
      p[2*k+1] = 1'h1;
      e[2*k] = PIN[k];
      e[2*k+1] = 1'h1;
    end
    sc(4'h1, 24, p);
    sc(4'h7, 24, p);
    chk("extest capture", e, d);
    chk("pad_out", DV, pad_out);
    chk("pad_oe", 32'hFFF, pad_oe);
    sc(4'h5, 1, 32'h0);
    chk("highz oe", 32'h0, pad_oe);
    sc(4'h4, 1, 32'h0);
    chk("clamp out", DV, pad_out);
    sc(4'h0, 1, 32'h0);
    chk("func out", 32'h0F0, pad_out);
    chk("func oe", 32'h00F, pad_oe);
    $display("done: pads");
  endtask
  task automatic t_regs();
    sc(4'hA, 15, {8'hC3, 7'h55});
    chk("gated write", 32'h0, wr_seen);
    sc(4'h8, 1, 32'h1);
    chk("link off", 32'h1, host_if_off);
    sc(4'hA, 15, {8'hC3, 7'h55});
    chk("write pulses", 32'h1, wr_seen);
    chk("reg_addr", 32'h55, reg_addr);
    chk("reg_wdata", 32'hC3, reg_wdata);
    sc(4'h9, 15, 32'h2A);
    chk("read chain", {8'hAB, 7'h55}, d);
    chk("new addr", 32'h2A, reg_addr);
    sc(4'h8, 1, 32'h0);
    chk("link on", 32'h0, host_if_off);
    $display("done: regs");
  endtask
  task automatic t_abort();
    jt.step(1'h1, 1'h1);
    jt.step(1'h0, 1'h1);
    jt.step(1'h0, 1'h1);
    repeat (40) @(negedge clk);
    chk("held shift", 32'h1, tdo_oe);
    jt.reset_tap();
    repeat (5) @(negedge clk);
    chk("tdo released", 32'h0, tdo_oe);
    jt.dr(32, 32'h0, d);
    chk("id after abort", ID, d);
    chk("oe while shifting", 32'h0, jt.oe_miss);
    $display("done: abort");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    repeat (10) @(negedge clk);
    t_ids();
    t_pads();
    t_regs();
    t_abort();
    print_verdict();
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
